//--- logic/cofd_pkg.sv
/*
  Shared constants and carrier types for the operand field decoder.
  Assumes a 16-bit instruction word source and an AXI4-Lite master.
*/
package cofd_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_ADDR = 8'h08;
  localparam logic [7:0] ADDR_LIT = 8'h0C;
  localparam logic [7:0] ADDR_MISC = 8'h10;
  localparam logic [7:0] ADDR_TABLE_PTR = 8'h14;
  localparam logic [7:0] ADDR_ALU = 8'h18;
  localparam logic [7:0] ADDR_PROD = 8'h1C;
  localparam logic [7:0] ADDR_PC = 8'h20;
  localparam logic [7:0] ADDR_PCLAT = 8'h24;
  localparam logic [7:0] ADDR_SHADOW = 8'h28;
  localparam logic [7:0] ADDR_SECOND = 8'h2C;
  // ==========================================================
  // Field positions
  localparam int D_BIT = 9;
  localparam int A_BIT = 8;
  localparam int S_BIT = 8;
  localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
  localparam logic [15:0] NOP_WORD = 16'hF000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Oscillator periods per instruction cycle
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);
  localparam logic [20:0] TABLE_PTR_RESET = 21'h00_0000;
  localparam logic [20:0] PC_RESET = 21'h00_0000;

  typedef enum logic [3:0]
  {
    COFD_TBL_KEEP = 4'b0001,
    COFD_TBL_POSTINC = 4'b0010,
    COFD_TBL_POSTDEC = 4'b0100,
    COFD_TBL_PREINC = 4'b1000
  } cofd_tbl_mode_t;

  typedef struct packed
  {
    logic [11:0] ram_addr;
    logic to_accumulator;
    logic to_file;
    logic [2:0] bit_num;
    logic [7:0] bit_mask;
    logic [7:0] file_addr;
    logic [1:0] ptr_sel;
    logic [11:0] move_src;
    logic [11:0] move_dst;
    logic [7:0] lit8;
    logic [11:0] lit12;
    logic [19:0] lit20;
    logic [6:0] idx_src;
    logic [6:0] idx_dst;
    logic [20:0] branch_target;
    logic fast_mode;
  } cofd_fields_t;
endpackage

//--- logic/cofd_decoder.sv
/*
  Operand field decoder with AXI4-Lite register access.
  Software loads an instruction word and context; the block decodes fields.
  Assumes a single clock and a well-behaved AXI4-Lite master.
*/
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
// What this block does
// RQ1: Access bit zero uses fixed access region
// RQ2: Access bit one uses bank select register
// RQ3: Three-bit field selects bit 0..7
// RQ4: Destination zero writes working accumulator
// RQ5: Destination one writes addressed register
// RQ6: Short operand: 8-bit address or pointer selector
// RQ7: Move source is full 12-bit address
// RQ8: Move destination is full 12-bit address
// RQ9: Literals extracted at 8, 12, 20 bits
// RQ10: Four table pointer modes applied
// RQ11: Branch offset relative; call/goto absolute
// RQ12: Fast bit zero: no shadow traffic
// RQ13: Fast bit one: save shadow registers, restore only accumulator and status
// RQ14: Table pointer is 21 bits wide
// RQ15: Seven-bit indexed source offset
// RQ16: Seven-bit indexed destination offset
// RQ17: Don't-care bits never change behaviour
// RQ18: Five arithmetic status flags kept
// RQ19: Product held in high/low bytes
// RQ20: PC writes take upper bits from latches
// RQ21: Second word tagged 1111 runs as no-op for table and ALU pulses; fast call/return is not blocked
// RQ22: Instruction cycle spans four oscillator periods
// RQ23: Fields presented in the decode cycle
`timescale 1ns/1ps
module cofd_decoder
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decoded fields to the datapath
  output cofd_pkg::cofd_fields_t fields,
  output logic cycle_end
);

  // ==========================================================
  // Software-visible state
  logic [15:0] instr_reg;
  logic [3:0] ctrl_reg;
  logic [3:0] bank_select_register;
  logic [7:0] working_accumulator;
  logic [4:0] status_reg;
  logic [7:0] operand_reg;
  logic [7:0] product_high_byte;
  logic [7:0] product_low_byte;
  logic [20:0] program_table_pointer;
  logic [7:0] program_table_latch;
  logic [20:0] pc_reg;
  logic [7:0] pc_high_latch;
  logic [4:0] pc_upper_latch;
  logic [7:0] shadow_acc_reg;
  logic [4:0] shadow_status_reg;
  logic [3:0] shadow_bank_reg;
  logic [1:0] phase_reg;
  logic [15:0] second_reg;
  logic second_nop_reg;

  // ==========================================================
  // Combinational decode
  cofd_pkg::cofd_fields_t fields_next;
  logic access_bit;
  logic dest_bit;
  always_comb
  begin
    access_bit = instr_reg[cofd_pkg::A_BIT];
    dest_bit = instr_reg[cofd_pkg::D_BIT];
    fields_next = '0;
    if (!access_bit)
    begin
      // Access region: low half of bank 0 or top half of last bank
      fields_next.ram_addr = instr_reg[7] ? {4'hF, instr_reg[7:0]} : {4'h0, instr_reg[7:0]}; // [RQ1]
    end
    else
    begin
      fields_next.ram_addr = {bank_select_register, instr_reg[7:0]}; // [RQ2]
    end
    fields_next.to_accumulator = ~dest_bit; // [RQ4]
    fields_next.to_file = dest_bit; // [RQ5]
    fields_next.bit_num = instr_reg[11:9]; // [RQ3]
    fields_next.bit_mask = 8'h01 << instr_reg[11:9]; // [RQ3]
    fields_next.file_addr = instr_reg[7:0]; // [RQ6]
    fields_next.ptr_sel = instr_reg[5:4]; // [RQ6]
    fields_next.move_src = instr_reg[11:0]; // [RQ7]
    fields_next.move_dst = second_reg[11:0]; // [RQ8]
    fields_next.lit8 = instr_reg[7:0]; // [RQ9]
    fields_next.lit12 = {instr_reg[3:0], second_reg[7:0]}; // [RQ9]
    fields_next.lit20 = {second_reg[11:0], instr_reg[7:0]}; // [RQ9]
    fields_next.idx_src = instr_reg[6:0]; // [RQ15]
    fields_next.idx_dst = second_reg[6:0]; // [RQ16]
    // Ctrl[0] chooses relative; unused bits are ignored [RQ17]
    if (ctrl_reg[0])
    begin
      fields_next.branch_target = 21'(pc_reg + 21'(signed'({instr_reg[10:0], 1'b0}))); // [RQ11]
    end
    else
    begin
      fields_next.branch_target = {second_reg[11:0], instr_reg[7:0], 1'b0}; // [RQ11]
    end
    fields_next.fast_mode = instr_reg[cofd_pkg::S_BIT];
  end

  // Decoded fields registered; updated every cycle for the current word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fields <= '0;
    end
    else
    begin
      fields <= fields_next; // [RQ23]
    end
  end

  // Instruction cycle phase counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_reg <= 2'h0;
      cycle_end <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_reg + 2'h1; // [RQ22]
      cycle_end <= (phase_reg == cofd_pkg::PHASE_LAST); // [RQ22]
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  logic [7:0] aw_addr_reg;
  logic aw_held;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held;
  logic do_write;
  logic [7:0] wa;
  logic [31:0] wd;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wa = aw_addr_reg;
  assign wd = w_data_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cofd_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa[1:0] != 2'b00 || wa > cofd_pkg::ADDR_SECOND) ? cofd_pkg::RESP_SLVERR
          : cofd_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write strobes ignored: full-word writes assumed
  logic wr_instr;
  logic wr_ctrl;
  logic wr_table_ptr;
  logic wr_alu;
  logic wr_pc;
  logic wr_pclat;
  logic wr_second;
  assign wr_instr = do_write && wa == cofd_pkg::ADDR_INSTR;
  assign wr_ctrl = do_write && wa == cofd_pkg::ADDR_CTRL;
  assign wr_table_ptr = do_write && wa == cofd_pkg::ADDR_TABLE_PTR;
  assign wr_alu = do_write && wa == cofd_pkg::ADDR_ALU;
  assign wr_pc = do_write && wa == cofd_pkg::ADDR_PC;
  assign wr_pclat = do_write && wa == cofd_pkg::ADDR_PCLAT;
  assign wr_second = do_write && wa == cofd_pkg::ADDR_SECOND;

  // Instruction and context registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      instr_reg <= cofd_pkg::NOP_WORD;
      second_reg <= cofd_pkg::NOP_WORD;
      second_nop_reg <= 1'b0;
      ctrl_reg <= 4'h0;
      bank_select_register <= 4'h0;
      operand_reg <= 8'h00;
    end
    else
    begin
      if (wr_instr)
      begin
        instr_reg <= wd[15:0];
        // Lone second word flagged; table and ALU pulses then do nothing
        second_nop_reg <= (wd[15:12] == cofd_pkg::SECOND_WORD_TAG); // [RQ21]
      end
      if (wr_second)
      begin
        second_reg <= wd[15:0];
      end
      if (wr_ctrl)
      begin
        ctrl_reg <= wd[3:0];
        bank_select_register <= wd[11:8];
      end
      if (wr_alu)
      begin
        operand_reg <= wd[23:16];
      end
    end
  end

  // Table pointer modes; ctrl[1] triggers one access
  cofd_pkg::cofd_tbl_mode_t tbl_mode;
  always_comb
  begin
    case (instr_reg[1:0])
      2'b00: tbl_mode = cofd_pkg::COFD_TBL_KEEP;
      2'b01: tbl_mode = cofd_pkg::COFD_TBL_POSTINC;
      2'b10: tbl_mode = cofd_pkg::COFD_TBL_POSTDEC;
      default: tbl_mode = cofd_pkg::COFD_TBL_PREINC;
    endcase
  end
  logic tbl_go;
  assign tbl_go = wr_ctrl && wd[1] && !second_nop_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      program_table_pointer <= cofd_pkg::TABLE_PTR_RESET;
      program_table_latch <= 8'h00;
    end
    else if (wr_table_ptr)
    begin
      program_table_pointer <= wd[20:0]; // [RQ14]
    end
    else if (tbl_go)
    begin
      case (tbl_mode) // [RQ10]
        cofd_pkg::COFD_TBL_KEEP: program_table_pointer <= program_table_pointer;
        cofd_pkg::COFD_TBL_POSTINC: program_table_pointer <= program_table_pointer + 21'h1;
        cofd_pkg::COFD_TBL_POSTDEC: program_table_pointer <= program_table_pointer - 21'h1;
        cofd_pkg::COFD_TBL_PREINC: program_table_pointer <= program_table_pointer + 21'h1;
        default: program_table_pointer <= program_table_pointer;
      endcase
      // Latch records the low byte of the address used by the access
      program_table_latch <= (tbl_mode == cofd_pkg::COFD_TBL_PREINC) ? 8'(program_table_pointer + 21'h1)
        : program_table_pointer[7:0];
    end
  end

  // ALU: ctrl[2] executes add/multiply on operand and accumulator
  logic alu_go;
  logic fast_save;
  logic fast_restore;
  logic [7:0] file_result_reg;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [15:0] prod;
  logic [7:0] result;
  assign alu_go = wr_ctrl && wd[2] && !second_nop_reg;
  assign sum = {1'b0, working_accumulator} + {1'b0, operand_reg};
  assign nib = {1'b0, working_accumulator[3:0]} + {1'b0, operand_reg[3:0]};
  assign prod = working_accumulator * operand_reg;
  assign result = sum[7:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      working_accumulator <= 8'h00;
      status_reg <= 5'h00;
      product_high_byte <= 8'h00;
      product_low_byte <= 8'h00;
    end
    else if (wr_alu)
    begin
      working_accumulator <= wd[7:0];
      status_reg <= wd[12:8];
    end
    else if (alu_go)
    begin
      // Flags: N OV Z DC C
      status_reg <= {result[7], (working_accumulator[7] == operand_reg[7]) && (result[7] != operand_reg[7]),
        result == 8'h00, nib[4], sum[8]}; // [RQ18]
      {product_high_byte, product_low_byte} <= prod; // [RQ19]
      if (!dest_bit)
      begin
        working_accumulator <= result; // [RQ4]
      end
    end
    else if (fast_restore)
    begin
      working_accumulator <= shadow_acc_reg; // [RQ13]
      status_reg <= shadow_status_reg; // [RQ13]
    end
  end

  // Result written back to file only when destination is one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      file_result_reg <= 8'h00;
    end
    else if (alu_go && dest_bit)
    begin
      file_result_reg <= result; // [RQ5]
    end
  end

  // Fast call/return: ctrl[3] call, wd[4] return
  assign fast_save = wr_ctrl && wd[3] && instr_reg[cofd_pkg::S_BIT]; // [RQ12]
  assign fast_restore = wr_ctrl && wd[4] && instr_reg[cofd_pkg::S_BIT] && !alu_go; // [RQ12]

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shadow_acc_reg <= 8'h00;
      shadow_status_reg <= 5'h00;
      shadow_bank_reg <= 4'h0;
    end
    else if (fast_save)
    begin
      shadow_acc_reg <= working_accumulator; // [RQ13]
      shadow_status_reg <= status_reg;
      shadow_bank_reg <= bank_select_register;
    end
  end

  // PC: writing low byte loads upper bits from latches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_reg <= cofd_pkg::PC_RESET;
      pc_high_latch <= 8'h00;
      pc_upper_latch <= 5'h00;
    end
    else
    begin
      if (wr_pclat)
      begin
        pc_high_latch <= wd[7:0];
        pc_upper_latch <= wd[12:8];
      end
      if (wr_pc)
      begin
        pc_reg <= {pc_upper_latch, pc_high_latch, wd[7:0]}; // [RQ20]
      end
    end
  end

  // ==========================================================
  // Read path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cofd_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= cofd_pkg::RESP_OKAY;
      case (s_axi_araddr)
        cofd_pkg::ADDR_INSTR: s_axi_rdata <= {15'h0000, second_nop_reg, instr_reg};
        cofd_pkg::ADDR_CTRL: s_axi_rdata <= {20'h0_0000, bank_select_register, 4'h0, ctrl_reg};
        cofd_pkg::ADDR_ADDR: s_axi_rdata <= {fields.move_dst, 7'h00, fields.to_file, fields.ram_addr};
        cofd_pkg::ADDR_LIT: s_axi_rdata <= {12'h000, fields.lit20};
        cofd_pkg::ADDR_MISC: s_axi_rdata <= {2'b00, fields.idx_dst, fields.idx_src, fields.bit_mask, 2'b00,
          fields.ptr_sel, fields.fast_mode, fields.bit_num};
        cofd_pkg::ADDR_TABLE_PTR: s_axi_rdata <= {3'h0, program_table_latch, program_table_pointer};
        cofd_pkg::ADDR_ALU: s_axi_rdata <= {file_result_reg, operand_reg, 3'h0, status_reg, working_accumulator};
        cofd_pkg::ADDR_PROD: s_axi_rdata <= {16'h0000, product_high_byte, product_low_byte};
        cofd_pkg::ADDR_PC: s_axi_rdata <= {11'h000, fields.branch_target};
        cofd_pkg::ADDR_PCLAT: s_axi_rdata <= {11'h000, pc_reg};
        cofd_pkg::ADDR_SHADOW: s_axi_rdata <= {15'h0000, shadow_bank_reg, shadow_status_reg, shadow_acc_reg};
        cofd_pkg::ADDR_SECOND: s_axi_rdata <= {16'h0000, second_reg};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= cofd_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

//--- verif/cofd_decoder_assertions.sv
/*
  Port-level checker for the operand field decoder.
  Assumes binding to cofd_decoder and one aclk domain.
*/
`timescale 1ns/1ps
module cofd_checker
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Decoded outputs
  input wire cofd_pkg::cofd_fields_t fields,
  input wire logic cycle_end
);
  default clocking cb @(posedge aclk);
  endclocking
  // ==========================================================
  // Instruction cycle
  sequence s_quiet_then_end;
    !cycle_end [*3] ##1 cycle_end;
  endsequence
  property p_cycle_period;
    disable iff (!aresetn) cycle_end |=> s_quiet_then_end;
  endproperty
  a_cycle_period: assert property (p_cycle_period)
    else $error("cycle end spacing is not four clocks");
  property p_cycle_live;
    disable iff (!aresetn) !cycle_end |-> ##[1:4] cycle_end;
  endproperty
  a_cycle_live: assert property (p_cycle_live)
    else $error("cycle end missing for four clocks");
  // ==========================================================
  // Field relations; first edge after reset still shows zeros
  property p_dest;
    disable iff (!aresetn) $past(aresetn) |-> fields.to_file != fields.to_accumulator;
  endproperty
  a_dest: assert property (p_dest)
    else $error("destination selects not exclusive");
  property p_mask;
    disable iff (!aresetn) $past(aresetn) |-> fields.bit_mask == (8'h01 << fields.bit_num);
  endproperty
  a_mask: assert property (p_mask)
    else $error("bit mask does not match bit number");
  property p_ram_low;
    disable iff (!aresetn) fields.ram_addr[7:0] == fields.file_addr;
  endproperty
  a_ram_low: assert property (p_ram_low)
    else $error("ram address low byte differs from file address");
  property p_move_src;
    disable iff (!aresetn) fields.move_src[7:0] == fields.file_addr;
  endproperty
  a_move_src: assert property (p_move_src)
    else $error("move source low byte differs from file address");
  property p_lit_parts;
    disable iff (!aresetn) fields.lit20 == {fields.move_dst, fields.lit8};
  endproperty
  a_lit_parts: assert property (p_lit_parts)
    else $error("wide literal not built from both words");
  // ==========================================================
  // Bus and reset
  property p_write_resp;
    disable iff (!aresetn) s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response not two clocks after offer");
  property p_read_resp;
    disable iff (!aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_resp: assert property (p_read_resp)
    else $error("read data not one clock after address");
  property p_reset;
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !cycle_end && fields == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
endmodule

bind cofd_decoder cofd_checker cofd_checker_inst
(
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .fields(fields),
  .cycle_end(cycle_end)
);

//--- verif/cofd_decoder_bench.sv
/*
  Self-checking bench for the operand field decoder over AXI4-Lite.
  Assumes the checker is bound to the design separately.
*/
`timescale 1ns/1ps
module cofd_decoder_bench;
  // ==========================================================
  // Signals
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [7:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  cofd_pkg::cofd_fields_t fields;
  logic cycle_end;
  int n_errors;
  int checks_done;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [15:0] acc_instr [4] = '{16'h247F, 16'h2680, 16'h25C3, 16'h27FF};
  logic [3:0] acc_bank [4] = '{4'h5, 4'h5, 4'h5, 4'hF};
  logic [11:0] acc_ram [4] = '{12'h07F, 12'hF80, 12'h5C3, 12'hFFF};
  logic [31:0] tb_start [5] = '{32'h0000_0100, 32'h0000_0100, 32'h0000_0100, 32'h0000_0100, 32'hFFFF_FFFF};
  logic [31:0] tb_exp [5] = '{32'h0000_0100, 32'h0000_0101, 32'h0000_00FF, 32'h0020_0101, 32'h1FE0_0000};
  logic [15:0] br_instr [2] = '{16'hD7FE, 16'hD005};
  logic [31:0] br_exp [2] = '{32'h0003_123C, 32'h0003_124A};

  cofd_decoder cofd_decoder_inst
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .fields(fields), .cycle_end(cycle_end)
  );

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ==========================================================
  // Verdict, compares and bus tasks
  task automatic end_of_test;
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("[FAIL] %s response expected %b seen %b", what, exp, got);
      n_errors++;
    end
  endtask

  // Bounded wait: a hung handshake ends the run
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 40)
    begin
      $display("[FAIL] bus handshake expected within 40 clocks seen none");
      n_errors++;
      end_of_test();
    end
  endtask

  // Ready lines are high when idle, so no second edge assignment races
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    int n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      tick(n);
      if (s_axi_awready && !aw_ok)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_ok)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid)
      tick(n);
    chk_resp("write", exp, s_axi_bresp);
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    tick(n);
    while (!s_axi_arready)
      tick(n);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid)
      tick(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    bus_read(a, d, r);
    chk_resp(what, cofd_pkg::RESP_OKAY, r);
    chk_val(what, exp, d & m);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_write(a, d, cofd_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    n_errors = 0;
    checks_done = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++)
    begin
      wr(cofd_pkg::ADDR_CTRL, 32'(acc_bank[i]) << 8);
      wr(cofd_pkg::ADDR_INSTR, 32'(acc_instr[i]));
      chk_val("ram_addr", 32'(acc_ram[i]), 32'(fields.ram_addr));
      chk_val("to_file", 32'(acc_instr[i][9]), 32'(fields.to_file));
      chk_val("to_accumulator", 32'(!acc_instr[i][9]), 32'(fields.to_accumulator));
      chk_val("file_addr", 32'(acc_instr[i][7:0]), 32'(fields.file_addr));
      rd_chk("bank select", cofd_pkg::ADDR_CTRL, 32'h0000_0F00, 32'(acc_bank[i]) << 8);
    end
    for (int b = 0; b < 8; b++)
    begin
      wr(cofd_pkg::ADDR_INSTR, 32'h0000_802A | (32'(b) << 9) | ((32'(b) & 32'h0000_0001) << 8));
      chk_val("bit_num", 32'(b), 32'(fields.bit_num));
      chk_val("bit_mask", 32'h0000_0001 << b, 32'(fields.bit_mask));
      chk_val("fast_mode", 32'(b) & 32'h0000_0001, 32'(fields.fast_mode));
    end
    wr(cofd_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(cofd_pkg::ADDR_SECOND, 32'h0000_F456);
    wr(cofd_pkg::ADDR_INSTR, 32'h0000_C123);
    chk_val("move_src", 32'h0000_0123, 32'(fields.move_src));
    chk_val("move_dst", 32'h0000_0456, 32'(fields.move_dst));
    chk_val("lit20", 32'h0004_5623, 32'(fields.lit20));
    chk_val("lit12 lit8", 32'h0003_5623, 32'({fields.lit12, fields.lit8}));
    chk_val("idx ptr", 32'h0000_475A, 32'({fields.idx_src, fields.idx_dst, fields.ptr_sel}));
    chk_val("absolute target", 32'h0008_AC46, 32'(fields.branch_target));
    rd_chk("second word", cofd_pkg::ADDR_SECOND, 32'h0000_FFFF, 32'h0000_F456);
    rd_chk("paired first word", cofd_pkg::ADDR_INSTR, 32'h0001_FFFF, 32'h0000_C123);
    // Lone second word: flagged, and a table pulse must do nothing
    wr(cofd_pkg::ADDR_TABLE_PTR, 32'h0000_0100);
    wr(cofd_pkg::ADDR_INSTR, 32'h0000_F456);
    rd_chk("lone word flag", cofd_pkg::ADDR_INSTR, 32'h0001_FFFF, 32'h0001_F456);
    wr(cofd_pkg::ADDR_CTRL, 32'h0000_0002);
    rd_chk("lone word as no-op", cofd_pkg::ADDR_TABLE_PTR, 32'h001F_FFFF, 32'h0000_0100);
    for (int i = 0; i < 5; i++)
    begin
      wr(cofd_pkg::ADDR_TABLE_PTR, tb_start[i]);
      wr(cofd_pkg::ADDR_INSTR, 32'h0000_0008 | (32'(i) & 32'h0000_0003) | (i == 4 ? 32'h0000_0001 : 32'h0000_0000));
      wr(cofd_pkg::ADDR_CTRL, 32'h0000_0002);
      rd_chk("table pointer", cofd_pkg::ADDR_TABLE_PTR, 32'h1FFF_FFFF, tb_exp[i]);
    end
    wr(cofd_pkg::ADDR_PCLAT, 32'h0000_0312);
    wr(cofd_pkg::ADDR_PC, 32'h0000_0040);
    rd_chk("pc from latches", cofd_pkg::ADDR_PCLAT, 32'h001F_FFFF, 32'h0003_1240);
    wr(cofd_pkg::ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i < 2; i++)
    begin
      wr(cofd_pkg::ADDR_INSTR, 32'(br_instr[i]));
      chk_val("relative target", br_exp[i], 32'(fields.branch_target));
      rd_chk("relative target read", cofd_pkg::ADDR_PC, 32'h001F_FFFF, br_exp[i]);
    end
    wr(cofd_pkg::ADDR_ALU, 32'h0034_0012);
    wr(cofd_pkg::ADDR_CTRL, 32'h0000_0004);
    rd_chk("product", cofd_pkg::ADDR_PROD, 32'h0000_FFFF, 32'h0000_03A8);
    rd_chk("alu", cofd_pkg::ADDR_ALU, 32'hFFFF_FFFF, 32'h0034_0046);
    wr(cofd_pkg::ADDR_CTRL, 32'h0000_0008);
    rd_chk("shadow", cofd_pkg::ADDR_SHADOW, 32'h0000_1FFF, 32'h0000_0000);
    wr(cofd_pkg::ADDR_INSTR, 32'h0000_0100);
    wr(cofd_pkg::ADDR_CTRL, 32'h0000_0008);
    rd_chk("shadow", cofd_pkg::ADDR_SHADOW, 32'h0000_1FFF, 32'h0000_0046);
    bus_write(8'h30, 32'h1234_5678, cofd_pkg::RESP_SLVERR);
    bus_write(8'h02, 32'h1234_5678, cofd_pkg::RESP_SLVERR);
    bus_read(8'h30, rd, rsp);
    chk_resp("unmapped read", cofd_pkg::RESP_SLVERR, rsp);
    chk_val("unmapped read data", 32'h0000_0000, rd);
    end_of_test();
  end
endmodule
